/* inc/lic_pkg.sv */
// package for the illumination control block
`default_nettype none
package lic_pkg;
  // color select codes
  localparam logic [1:0] LIC_SEL_NONE  = 2'h0;
  localparam logic [1:0] LIC_SEL_RED   = 2'h1;
  localparam logic [1:0] LIC_SEL_GREEN = 2'h2;
  localparam logic [1:0] LIC_SEL_BLUE  = 2'h3;
  // timing
  localparam int unsigned LIC_CLK_HZ     = 20000000;
  localparam int unsigned LIC_ON_DELAY_MS = 100;
  localparam int unsigned LIC_ON_DELAY_CYC = (LIC_CLK_HZ / 1000) * LIC_ON_DELAY_MS;
  // reset values
  localparam logic [2:0] LIC_PWM_RST  = 3'h7;
  localparam logic [2:0] LIC_CEN_RST  = 3'h0;
  // per-color bundle, index 0 red, 1 green, 2 blue
  typedef struct packed {
    logic blue;
    logic green;
    logic red;
  } lic_rgb_t;
  // delay sequencer states
  typedef enum logic [1:0] {
    LIC_ST_OFF  = 2'b00,
    LIC_ST_WAIT = 2'b01,
    LIC_ST_ON   = 2'b10
  } lic_state_t;
endpackage
`default_nettype wire

/* hw/lic_top.sv */
// illumination control outputs toward an external led driver
// Operation
// (R01) one current pwm output per color: red, green, blue
// (R02) two-bit color select: 00 none, 01 red, 10 green, 11 blue
// (R03) external decoder turns color select into single led enables
// (R04) master driver enable rises 100 ms after illumination enable rises
// (R05) master driver enable drops at once when enable or power good falls
// (R06) enable low holds master enable low and color select at 00
// (R07) color select and master enable released only after 100 ms delay
// (R08) per-color enable output high turns led on, low turns it off
// (R09) per-color enables driven low until software control write enables them
// (R10) pwm outputs forced high when master off, software off, or sequence stopped
// (R11) delay counter on system clock restarts when enable or power good drops
`default_nettype none
module lic_top
  import lic_pkg::*;
#(
  parameter int unsigned ON_DELAY_CYC = LIC_ON_DELAY_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  // asynchronous pins
  input  wire logic       illum_enable_in,
  input  wire logic       power_good_in,
  // internal sequence and control
  input  wire logic       seq_running,
  input  wire logic       sw_led_ctrl_en,
  input  wire logic [1:0] seq_color,
  input  wire lic_rgb_t   seq_pwm,
  input  wire logic       cen_write,
  input  wire lic_rgb_t   cen_wdata,
  // driver pins
  output logic            red_current_pwm,
  output logic            green_current_pwm,
  output logic            blue_current_pwm,
  output logic [1:0]      color_select,
  output logic            driver_master_enable,
  output lic_rgb_t        color_en_out
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] en_sync_reg;
  logic [2:0] pg_sync_reg;
  logic       en_lvl_reg;
  logic       pg_lvl_reg;

  // three-stage shift, only stages 2 and 3 are compared
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_sync_reg <= 3'h0;
      pg_sync_reg <= 3'h0;
    end else if (clk_en) begin
      en_sync_reg <= {en_sync_reg[1:0], illum_enable_in};
      pg_sync_reg <= {pg_sync_reg[1:0], power_good_in};
    end
  end

  // level follows once stages 2 and 3 agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_lvl_reg <= 1'b0;
      pg_lvl_reg <= 1'b0;
    end else if (clk_en) begin
      if (en_sync_reg[1] == en_sync_reg[2]) begin
        en_lvl_reg <= en_sync_reg[2];
      end
      if (pg_sync_reg[1] == pg_sync_reg[2]) begin
        pg_lvl_reg <= pg_sync_reg[2];
      end
    end
  end

  logic go;
  assign go = en_lvl_reg & pg_lvl_reg;

  // ----------------------------------------------------------------
  // turn-on delay sequencer
  // ----------------------------------------------------------------
  lic_state_t  state_reg;
  lic_state_t  state_next;
  logic [31:0] dly_cnt_reg;

  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LIC_ST_OFF: begin
        if (go) begin
          state_next = LIC_ST_WAIT;
        end
      end
      LIC_ST_WAIT: begin
        if (!go) begin
          state_next = LIC_ST_OFF;
        end else if (dly_cnt_reg >= ON_DELAY_CYC - 1) begin
          state_next = LIC_ST_ON;
        end
      end
      LIC_ST_ON: begin
        if (!go) begin
          state_next = LIC_ST_OFF;
        end
      end
      default: begin
        state_next = LIC_ST_OFF;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= LIC_ST_OFF;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // (R11) restartable delay counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dly_cnt_reg <= 32'h0;
    end else if (clk_en) begin
      if (state_reg != LIC_ST_WAIT || !go) begin
        dly_cnt_reg <= 32'h0;
      end else begin
        dly_cnt_reg <= dly_cnt_reg + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // driver outputs
  // ----------------------------------------------------------------
  logic master_on;
  // (R05) immediate drop on enable or power good low
  assign master_on = (state_reg == LIC_ST_ON) & go;

  // (R04) master enable after delay, dropped at once
  always_comb begin
    driver_master_enable = master_on;
  end

  // (R02) color select from sequence timing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      color_select <= LIC_SEL_NONE;
    end else if (clk_en) begin
      // (R06) (R07) forced none until released
      if (!(state_next == LIC_ST_ON)) begin
        color_select <= LIC_SEL_NONE;
      end else begin
        color_select <= seq_color;
      end
    end
  end

  // (R01) (R10) pwm outputs, forced high when idle
  lic_rgb_t pwm_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwm_reg <= LIC_PWM_RST;
    end else if (clk_en) begin
      if (state_next != LIC_ST_ON || !sw_led_ctrl_en || !seq_running) begin
        pwm_reg <= LIC_PWM_RST;
      end else begin
        pwm_reg <= seq_pwm;
      end
    end
  end
  assign red_current_pwm   = pwm_reg.red | ~master_on;
  assign green_current_pwm = pwm_reg.green | ~master_on;
  assign blue_current_pwm  = pwm_reg.blue | ~master_on;

  // (R08) (R09) per-color enables, low until written
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      color_en_out <= LIC_CEN_RST;
    end else if (clk_en && cen_write) begin
      color_en_out <= cen_wdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence go_fall_s;
    $fell(go);
  endsequence

  drop_now_a: assert property (@(posedge clk) disable iff (!nrst) // R05
    go_fall_s |-> !driver_master_enable)
    else $error("master enable not dropped at once");

  sel_off_a: assert property (@(posedge clk) disable iff (!nrst) // R06
    !driver_master_enable && $past(!driver_master_enable) |-> color_select == LIC_SEL_NONE)
    else $error("color select not forced to none");

  pwm_force_a: assert property (@(posedge clk) disable iff (!nrst) // R10
    !driver_master_enable |-> red_current_pwm && green_current_pwm && blue_current_pwm)
    else $error("pwm not forced high");

  on_delay_a: assert property (@(posedge clk) disable iff (!nrst) // R04
    $rose(driver_master_enable) |-> $past(dly_cnt_reg) == ON_DELAY_CYC - 1
      && $past(state_reg) == LIC_ST_WAIT)
    else $error("master enable rose without delay");

  cnt_restart_a: assert property (@(posedge clk) disable iff (!nrst) // R11
    clk_en && !go |=> dly_cnt_reg == 32'h0)
    else $error("delay counter not restarted");

  cen_hold_a: assert property (@(posedge clk) disable iff (!nrst) // R09
    !cen_write |=> $stable(color_en_out))
    else $error("color enable changed without write");

endmodule
`default_nettype wire

/* verif/lic_led_decoder.sv */
// external led driver decode model for the color select code
`default_nettype none
module lic_led_decoder
  import lic_pkg::*;
(
  // select from the block
  input  wire logic [1:0] color_select,
  input  wire logic       driver_master_enable,
  // decoded led enables
  output var  lic_rgb_t   led_on
);
  // ----------
  // decode
  // ----------
  // one-hot led decode
  always_comb begin
    led_on       = '0;
    led_on.red   = driver_master_enable && (color_select == LIC_SEL_RED);
    led_on.green = driver_master_enable && (color_select == LIC_SEL_GREEN);
    led_on.blue  = driver_master_enable && (color_select == LIC_SEL_BLUE);
  end
endmodule
`default_nettype wire

/* verif/led_illumination_control_tb.sv */
// self-checking bench for the illumination control block
`default_nettype none
module led_illumination_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lic_pkg::*;
  localparam int unsigned DLY = 20;
  logic clk, nrst, clk_en, illum_enable_in, power_good_in, seq_running, sw_led_ctrl_en;
  logic cen_write, red_current_pwm, green_current_pwm, blue_current_pwm, driver_master_enable;
  logic [1:0] seq_color, color_select;
  logic [2:0] pwm;
  lic_rgb_t   seq_pwm, cen_wdata, color_en_out, led_on;
  lic_rgb_t   cen_q[$];
  int         failures, samples_checked, n;
  assign pwm = {blue_current_pwm, green_current_pwm, red_current_pwm};
  lic_top #(.ON_DELAY_CYC(DLY)) u_lic_top (.clk(clk), .nrst(nrst), .clk_en(clk_en),
    .illum_enable_in(illum_enable_in), .power_good_in(power_good_in),
    .seq_running(seq_running), .sw_led_ctrl_en(sw_led_ctrl_en), .seq_color(seq_color),
    .seq_pwm(seq_pwm), .cen_write(cen_write), .cen_wdata(cen_wdata),
    .red_current_pwm(red_current_pwm), .green_current_pwm(green_current_pwm),
    .blue_current_pwm(blue_current_pwm), .color_select(color_select),
    .driver_master_enable(driver_master_enable), .color_en_out(color_en_out));
  lic_led_decoder u_lic_led_decoder (.color_select(color_select),
    .driver_master_enable(driver_master_enable), .led_on(led_on));
  // ----------
  // tasks
  // ----------
  task automatic chk(input string what, input logic [2:0] seen, input logic [2:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask
  // bounded wait for the master enable level
  task automatic wait_master(input logic v, input int lim);
    n = 0;
    while (driver_master_enable !== v) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        chk("master wait", {2'h0, driver_master_enable}, {2'h0, v});
        finish_test();
      end
    end
  endtask
  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------
  // sequence
  // ----------
  initial begin
    void'($urandom(32'haa62));
    {nrst, illum_enable_in, power_good_in, seq_running, sw_led_ctrl_en, cen_write} = '0;
    {clk_en, seq_color, seq_pwm, cen_wdata, failures, samples_checked} = '0;
    clk_en = 1'b1;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    cyc(1);
    chk("pwm", pwm, LIC_PWM_RST);
    chk("cen", color_en_out, LIC_CEN_RST);
    @(posedge clk);
    {illum_enable_in, power_good_in, seq_running, sw_led_ctrl_en} <= 4'hF;
    seq_color <= LIC_SEL_BLUE;
    cyc(DLY);
    chk("sel", {1'b0, color_select}, 3'h0);
    wait_master(1'b1, 10);
    chk("delay", 3'(DLY + n >= DLY + 3 && DLY + n <= DLY + 6), 3'h1);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      seq_color <= k[1:0];
      seq_pwm <= lic_rgb_t'(3'($urandom));
      cyc(2);
      chk("sel", {1'b0, color_select}, 3'(k));
      chk("led", led_on, 3'(k == 0 ? 0 : 1 << (k - 1)));
      chk("pwm", pwm, seq_pwm);
    end
    @(posedge clk);
    seq_pwm <= '0;
    sw_led_ctrl_en <= 1'b0;
    cyc(2);
    chk("pwm", pwm, 3'h7);
    @(posedge clk);
    {sw_led_ctrl_en, seq_running} <= 2'h2;
    cyc(2);
    chk("pwm", pwm, 3'h7);
    // back-to-back enable writes, last one stands
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      cen_q.push_back(lic_rgb_t'(3'($urandom)));
      cen_write <= 1'b1;
      cen_wdata <= cen_q[$];
    end
    @(posedge clk);
    cen_write <= 1'b0;
    cyc(1);
    chk("cen", color_en_out, cen_q[$]);
    // frozen clock enable ignores a write strobe
    @(posedge clk);
    clk_en <= 1'b0;
    cen_write <= 1'b1;
    cen_wdata <= ~cen_q[$];
    cyc(2);
    chk("cen", color_en_out, cen_q[$]);
    @(posedge clk);
    {clk_en, cen_write} <= 2'h2;
    @(posedge clk);
    power_good_in <= 1'b0;
    wait_master(1'b0, 6);
    @(posedge clk);
    power_good_in <= 1'b1;
    seq_running <= 1'b1;
    cyc(DLY);
    chk("master", {2'h0, driver_master_enable}, 3'h0);
    wait_master(1'b1, 10);
    chk("pwm", pwm, seq_pwm);
    @(posedge clk);
    illum_enable_in <= 1'b0;
    wait_master(1'b0, 6);
    cyc(2);
    chk("sel", {1'b0, color_select}, 3'h0);
    chk("pwm", pwm, 3'h7);
    finish_test();
  end
endmodule
`default_nettype wire
